// ==== zscm_mixer.v ====
// Zero-stuffing stage and complex mixer in front of the DAC core, with its input FIFO
// Function
// - Control bit 3 of register 01h enables zero stuffing when set to one.
// - While stuffing, a midscale code 8000h follows every sample from the filter path.
// - Stuffing doubles the DAC sample rate against the input sample rate.
// - Zero insertion sits after the modulator, so stuffed samples are never mixed.
// - Control bit 2 of register 01h couples I and Q into one complex mixer.
// - Control bit 1 picks carrier exponent sign, flipping the sine term.
// - Complex carrier frequency uses the same rate field: half, quarter or eighth.
// - Modulation rate selection is held in bits 5 and 4 of register 01h.
`timescale 1ns/100ps
`include "zscm_regs.vh"

// ----------------------------------------------------------------------------
// Sample FIFO
// ----------------------------------------------------------------------------
module zscm_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             ref_clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] wr_data,
  input  wire             wr_valid,
  output wire             wr_ready,
  output wire [WIDTH-1:0] rd_data,
  output wire             rd_valid,
  input  wire             rd_ready
);
  // Four words absorb a back-to-back burst while stuffing halves the drain rate
  // Storage is not reset: a word is only read once valid_reg vouches for it
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  reg [AW:0]      count_next;
  reg             ready_reg;
  reg             valid_reg;
  wire            push;
  wire            pop;

  assign push     = wr_valid & ready_reg;
  assign pop      = rd_ready & valid_reg;
  assign wr_ready = ready_reg;
  assign rd_valid = valid_reg;
  assign rd_data  = mem_reg[rd_ptr_reg];

  always @* begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
      ready_reg  <= 1'b1;
      valid_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      // Flags are registered so full and empty never depend on the far side's strobes
      ready_reg <= (count_next != DEPTH[AW:0]);
      valid_reg <= (count_next != {(AW+1){1'b0}});
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= wr_data;
    end
  end
endmodule

// ----------------------------------------------------------------------------
// Top: modulator followed by zero stuffing
// ----------------------------------------------------------------------------
module zscm_mixer (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire [15:0] in_i,
  input  wire [15:0] in_q,
  input  wire        in_valid,
  output wire        in_ready,
  input  wire [1:0]  mod_rate,
  input  wire        zero_stuff_en,
  input  wire        complex_mix_en,
  input  wire        pos_exp_sel,
  output reg  [15:0] dac_i_code,
  output reg  [15:0] dac_q_code,
  output reg         dac_stuffed,
  output reg         dac_underrun
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Signed sample times Q15 coefficient, result kept wide for the sum
  function signed [18:0] zscm_mul;
    input signed [15:0] x;
    input signed [17:0] c;
    reg   signed [33:0] p;
    begin
      p        = x * c;
      zscm_mul = p[33:15];
    end
  endfunction

  // Saturate to 16 bits; complex sums can reach 1.414 of full scale
  function [15:0] zscm_sat;
    input signed [19:0] v;
    begin
      if (v > 20'sd32767) begin
        zscm_sat = 16'h7FFF;
      end else if (v < -20'sd32768) begin
        zscm_sat = 16'h8000;
      end else begin
        zscm_sat = v[15:0];
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // Input FIFO
  // --------------------------------------------------------------------------
  wire [31:0] head_data;
  wire        head_valid;
  wire        take;

  zscm_fifo #(
    .WIDTH (32),
    .DEPTH (`ZSCM_FIFO_DEPTH),
    .AW    (`ZSCM_FIFO_AW)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .wr_data  ({in_i, in_q}),
    .wr_valid (in_valid),
    .wr_ready (in_ready),
    .rd_data  (head_data),
    .rd_valid (head_valid),
    .rd_ready (take)
  );

  // --------------------------------------------------------------------------
  // Stuffing slot and carrier phase
  // --------------------------------------------------------------------------
  reg        stuff_slot_reg;
  reg [2:0]  phase_reg;
  reg [2:0]  phase_step;
  wire       data_slot;

  // With stuffing every second DAC cycle is a midscale slot, so input rate halves
  assign data_slot = !zero_stuff_en || !stuff_slot_reg;
  assign take      = data_slot && head_valid;

  always @* begin
    case (mod_rate)
      `ZSCM_MOD_HALF:    phase_step = `ZSCM_STEP_HALF;
      `ZSCM_MOD_QUARTER: phase_step = `ZSCM_STEP_QUARTER;
      `ZSCM_MOD_EIGHTH:  phase_step = `ZSCM_STEP_EIGHTH;
      default:           phase_step = `ZSCM_STEP_NONE;
    endcase
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      stuff_slot_reg <= 1'b0;
      phase_reg      <= 3'h0;
    end else begin
      // Slot flop parks at zero while disabled, so enabling starts on a data slot
      stuff_slot_reg <= zero_stuff_en ? !stuff_slot_reg : 1'b0;
      // Carrier advances per modulated sample only, never per stuffed slot
      // Limitation: a mid-stream rate change keeps the current phase, no re-zero
      if (take) begin
        phase_reg <= phase_reg + phase_step;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Carrier lookup
  // --------------------------------------------------------------------------
  reg signed [17:0] cos_c;
  reg signed [17:0] sin_c;

  // Eight-point wheel: entry k is the cosine and sine of k times 45 degrees
  // Half rate only visits entries 0 and 4, where sine is zero: no quadrature there
  always @* begin
    case (phase_reg)
      3'h0: begin
        cos_c = `ZSCM_COEF_ONE;
        sin_c = `ZSCM_COEF_ZERO;
      end
      3'h1: begin
        cos_c = `ZSCM_COEF_RT2;
        sin_c = `ZSCM_COEF_RT2;
      end
      3'h2: begin
        cos_c = `ZSCM_COEF_ZERO;
        sin_c = `ZSCM_COEF_ONE;
      end
      3'h3: begin
        cos_c = -`ZSCM_COEF_RT2;
        sin_c = `ZSCM_COEF_RT2;
      end
      3'h4: begin
        cos_c = -`ZSCM_COEF_ONE;
        sin_c = `ZSCM_COEF_ZERO;
      end
      3'h5: begin
        cos_c = -`ZSCM_COEF_RT2;
        sin_c = -`ZSCM_COEF_RT2;
      end
      3'h6: begin
        cos_c = `ZSCM_COEF_ZERO;
        sin_c = -`ZSCM_COEF_ONE;
      end
      default: begin
        cos_c = `ZSCM_COEF_RT2;
        sin_c = -`ZSCM_COEF_RT2;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Mixer
  // --------------------------------------------------------------------------
  wire signed [15:0] s_i;
  wire signed [15:0] s_q;
  wire signed [17:0] sin_s;
  wire signed [18:0] ic;
  wire signed [18:0] is;
  wire signed [18:0] qc;
  wire signed [18:0] qs;
  reg  signed [19:0] re_sum;
  reg  signed [19:0] im_sum;

  assign s_i   = head_data[31:16];
  assign s_q   = head_data[15:0];
  // Negative exponent flips the sine term, moving the rejected sideband
  assign sin_s = pos_exp_sel ? sin_c : -sin_c;
  // Products keep Q15 scaling; the floor from the arithmetic shift is deliberate
  // Complex overrange clips rather than wraps, trading distortion for no sign flips
  assign ic    = zscm_mul(s_i, cos_c);
  assign is    = zscm_mul(s_i, sin_s);
  assign qc    = zscm_mul(s_q, cos_c);
  assign qs    = zscm_mul(s_q, sin_s);

  always @* begin
    // No carrier selected: samples pass straight through
    if (mod_rate == `ZSCM_MOD_NONE) begin
      re_sum = {{4{s_i[15]}}, s_i};
      im_sum = {{4{s_q[15]}}, s_q};
    end else if (complex_mix_en) begin
      // Half rate has no quadrature partner: sine is zero there, so only cos acts
      re_sum = {ic[18], ic} - {qs[18], qs};
      im_sum = {is[18], is} + {qc[18], qc};
    end else begin
      re_sum = {ic[18], ic};
      im_sum = {qc[18], qc};
    end
  end

  // --------------------------------------------------------------------------
  // Zero stuffing and DAC output
  // --------------------------------------------------------------------------
  // Underrun sends midscale too, so a starved filter never repeats a stale code
  // Every output is a flop, so the DAC core sees one clean word per edge
  always @(posedge ref_clk) begin
    if (reset) begin
      dac_i_code   <= `ZSCM_MIDSCALE;
      dac_q_code   <= `ZSCM_MIDSCALE;
      dac_stuffed  <= 1'b0;
      dac_underrun <= 1'b0;
    end else if (take) begin
      // Twos complement to offset binary: flip the sign bit
      dac_i_code   <= zscm_sat(re_sum) ^ `ZSCM_MIDSCALE;
      dac_q_code   <= zscm_sat(im_sum) ^ `ZSCM_MIDSCALE;
      dac_stuffed  <= 1'b0;
      dac_underrun <= 1'b0;
    end else begin
      // Inserted after the mixer, so this code is never modulated
      dac_i_code   <= `ZSCM_MIDSCALE;
      dac_q_code   <= `ZSCM_MIDSCALE;
      dac_stuffed  <= !data_slot;
      dac_underrun <= data_slot;
    end
  end
endmodule

// ==== zscm_mixer_sva.sv ====
// Port assertions for the zero-stuffing complex mixer
`timescale 1ns/100ps
module zscm_mixer_sva (
  input wire        ref_clk,
  input wire        reset,
  input wire [15:0] in_i,
  input wire [15:0] in_q,
  input wire        in_valid,
  input wire        in_ready,
  input wire [1:0]  mod_rate,
  input wire        zero_stuff_en,
  input wire        complex_mix_en,
  input wire        pos_exp_sel,
  input wire [15:0] dac_i_code,
  input wire [15:0] dac_q_code,
  input wire        dac_stuffed,
  input wire        dac_underrun
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_rst; disable iff (1'b0) reset |=> dac_i_code == 16'h8000
    && dac_q_code == 16'h8000 && !dac_stuffed && !dac_underrun && in_ready; endproperty
  a_rst: assert property (p_rst) else $error("bad reset outputs");
  property p_mid; dac_stuffed |-> dac_i_code == 16'h8000 && dac_q_code == 16'h8000; endproperty
  a_mid: assert property (p_mid) else $error("stuffed word not midscale");
  property p_alt; zero_stuff_en [*3] ##0 (!dac_stuffed && !$past(reset)) |=> dac_stuffed;
  endproperty
  a_alt: assert property (p_alt) else $error("no midscale after sample");
  property p_once; dac_stuffed |=> !dac_stuffed; endproperty
  a_once: assert property (p_once) else $error("two stuffed words in a row");
  property p_off; !zero_stuff_en && !$past(zero_stuff_en) |-> !dac_stuffed; endproperty
  a_off: assert property (p_off) else $error("stuffing while disabled");
  property p_under; dac_underrun |-> !dac_stuffed && dac_i_code == 16'h8000; endproperty
  a_under: assert property (p_under) else $error("underrun word not midscale");
  property p_lat; (in_valid && in_ready && dac_underrun && !zero_stuff_en && mod_rate == 2'h0)
    ##1 (!zero_stuff_en && mod_rate == 2'h0) |=> dac_i_code == ($past(in_i, 2) ^ 16'h8000)
    && dac_q_code == ($past(in_q, 2) ^ 16'h8000); endproperty
  a_lat: assert property (p_lat) else $error("plain sample not passed on");
  property p_full; $fell(in_ready) |-> $past(in_valid); endproperty
  a_full: assert property (p_full) else $error("ready fell with no write");
endmodule
bind zscm_mixer zscm_mixer_sva u_sva (
  .ref_clk        (ref_clk),
  .reset          (reset),
  .in_i           (in_i),
  .in_q           (in_q),
  .in_valid       (in_valid),
  .in_ready       (in_ready),
  .mod_rate       (mod_rate),
  .zero_stuff_en  (zero_stuff_en),
  .complex_mix_en (complex_mix_en),
  .pos_exp_sel    (pos_exp_sel),
  .dac_i_code     (dac_i_code),
  .dac_q_code     (dac_q_code),
  .dac_stuffed    (dac_stuffed),
  .dac_underrun   (dac_underrun)
);

// ==== zscm_mixer_tb.sv ====
// Self-checking bench for the zero-stuffing complex mixer
`timescale 1ns/100ps
module zscm_mixer_tb;
  logic        ref_clk = 0, reset = 1, zero_stuff_en = 0, complex_mix_en = 0, pos_exp_sel = 0;
  logic [1:0]  mod_rate = 0;
  logic        rst_d1 = 1, rst_d2 = 1;
  wire  [15:0] in_i, in_q, dac_i_code, dac_q_code;
  wire         in_valid, in_ready, dac_stuffed, dac_underrun;
  logic [31:0] exp_q[$];
  int          n_fail = 0, n_checks = 0, n_stuff, n_under, n_full, ph;
  always #12.5 ref_clk = ~ref_clk;
  zscm_src src (.ref_clk(ref_clk), .in_ready(in_ready), .in_i(in_i), .in_q(in_q),
    .in_valid(in_valid));
  zscm_mixer DUT (
    .ref_clk        (ref_clk),
    .reset          (reset),
    .in_i           (in_i),
    .in_q           (in_q),
    .in_valid       (in_valid),
    .in_ready       (in_ready),
    .mod_rate       (mod_rate),
    .zero_stuff_en  (zero_stuff_en),
    .complex_mix_en (complex_mix_en),
    .pos_exp_sel    (pos_exp_sel),
    .dac_i_code     (dac_i_code),
    .dac_q_code     (dac_q_code),
    .dac_stuffed    (dac_stuffed),
    .dac_underrun   (dac_underrun)
  );
  task check(input logic [31:0] got, input logic [31:0] want);
    n_checks++;
    if (got !== want) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  function automatic logic [15:0] sat(input int v);
    return (v > 32767 ? 16'h7FFF : v < -32768 ? 16'h8000 : v[15:0]) ^ 16'h8000;
  endfunction
  // Sine wheel in 45 degree steps; cosine is two steps ahead
  function automatic logic [31:0] mix(input logic [15:0] i, input logic [15:0] q, input int p);
    int sn[8] = '{0, 23170, 32768, 23170, 0, -23170, -32768, -23170};
    int c, s, re, im;
    c = sn[(p + 2) % 8];
    s = (mod_rate == 2'h1 || !complex_mix_en) ? 0 : (pos_exp_sel ? sn[p] : -sn[p]);
    re = ((int'($signed(i)) * c) >>> 15) - ((int'($signed(q)) * s) >>> 15);
    im = ((int'($signed(i)) * s) >>> 15) + ((int'($signed(q)) * c) >>> 15);
    return {sat(re), sat(im)};
  endfunction
  always @(posedge ref_clk) begin
    rst_d1 <= reset;
    rst_d2 <= rst_d1;
    if (!reset && !rst_d1 && !rst_d2) begin
      if (dac_stuffed) n_stuff++;
      if (dac_underrun) n_under++;
      if (!in_ready) n_full++;
      if (dac_stuffed || dac_underrun) check({dac_i_code, dac_q_code}, 32'h80008000);
      if (!dac_stuffed && !dac_underrun) begin
        if (exp_q.size() == 0) check(32'(exp_q.size()), 32'h1);
        else check({dac_i_code, dac_q_code}, exp_q.pop_front());
      end
    end
  end
  task run(input logic [1:0] mr, input logic zs, cm, pe, input int n, gap);
    reset <= 1;
    mod_rate <= mr;
    zero_stuff_en <= zs;
    complex_mix_en <= cm;
    pos_exp_sel <= pe;
    repeat (2) @(posedge ref_clk);
    reset <= 0;
    ph = 0;
    n_stuff = 0;
    n_under = 0;
    n_full = 0;
    for (int k = 0; k < n; k++) begin
      exp_q.push_back(mix(16'h2100 - 16'(k * 1328), 16'(k * 977) - 16'h1800, ph));
      ph = (ph + (mr == 2'h0 ? 0 : 8 >> mr)) % 8;
      src.send(16'h2100 - 16'(k * 1328), 16'(k * 977) - 16'h1800, gap);
    end
    if (gap == 0) src.idle();
    for (int t = 0; t < 40 && exp_q.size() != 0; t++) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
    check(32'(exp_q.size()), 32'h0);
    check(32'({n_stuff > 0, n_full > 0, n_under > 0}), 32'({zs, zs && gap == 0, 1'b1}));
  endtask
  task results;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    results();
  end
  initial begin
    run(2'h0, 0, 0, 0, 6, 0);
    run(2'h0, 1, 0, 0, 10, 0);
    run(2'h1, 0, 0, 0, 4, 1);
    run(2'h2, 0, 0, 0, 8, 0);
    run(2'h3, 1, 0, 0, 10, 2);
    run(2'h2, 0, 1, 1, 8, 0);
    run(2'h2, 0, 1, 0, 8, 0);
    run(2'h3, 0, 1, 1, 8, 0);
    run(2'h3, 1, 1, 0, 8, 0);
    run(2'h1, 0, 1, 1, 4, 0);
    results();
  end
endmodule

// ==== zscm_regs.vh ====
// Constants for the zero-stuffing and complex-mix back end
`ifndef ZSCM_REGS_VH
`define ZSCM_REGS_VH

// Control register 01h bit positions (the register itself stays outside this block)
`define ZSCM_CTRL_ADDR        8'h01
`define ZSCM_BIT_MODRATE_HI   5
`define ZSCM_BIT_MODRATE_LO   4
`define ZSCM_BIT_ZSTUFF       3
`define ZSCM_BIT_CMIX         2
`define ZSCM_BIT_POSEXP       1

// Modulation-rate codes
`define ZSCM_MOD_NONE         2'h0
`define ZSCM_MOD_HALF         2'h1
`define ZSCM_MOD_QUARTER      2'h2
`define ZSCM_MOD_EIGHTH       2'h3

// Carrier phase steps on an eight-point phase wheel
`define ZSCM_STEP_NONE        3'h0
`define ZSCM_STEP_HALF        3'h4
`define ZSCM_STEP_QUARTER     3'h2
`define ZSCM_STEP_EIGHTH      3'h1

// Midscale code as it leaves for the DAC core (offset binary)
`define ZSCM_MIDSCALE         16'h8000

// Carrier magnitudes in Q15, carried at 18 bits so that +1.0 fits
`define ZSCM_COEF_ONE         18'h08000
`define ZSCM_COEF_RT2         18'h05A82
`define ZSCM_COEF_ZERO        18'h00000

// Depth of the sample FIFO in front of the mixer
`define ZSCM_FIFO_DEPTH       4
`define ZSCM_FIFO_AW          2

`endif

// ==== zscm_src.sv ====
// Sample source standing in for the interpolation filter chain
`timescale 1ns/100ps
module zscm_src (
  input  wire         ref_clk,
  input  wire         in_ready,
  output logic [15:0] in_i,
  output logic [15:0] in_q,
  output logic        in_valid
);
  initial begin
    in_valid = 1'b0;
    in_i = 16'h0;
    in_q = 16'h0;
  end
  // Released data is inverted so stale words never look valid
  task idle;
    in_valid <= 1'b0;
    in_i <= ~in_i;
    in_q <= ~in_q;
  endtask
  task send(input logic [15:0] i, input logic [15:0] q, input int gap);
    in_i <= i;
    in_q <= q;
    in_valid <= 1'b1;
    do @(posedge ref_clk); while (in_ready !== 1'b1);
    if (gap > 0) begin
      idle();
      repeat (gap) @(posedge ref_clk);
    end
  endtask
endmodule
